// ==== common/lvd_pkg.sv ====
// Constants and types shared by the 21-bit deserializer files
// Behaviour
// - Three serial lanes are turned into one 21-bit parallel word every link clock period.
// - The link clock must stay inside the supported band, and the receiver must lock anywhere across it; the code locks only for periods up to 40 mclk cycles.
// - Every lane carries seven bits in each link clock period.
// - The rising edge of the recovered clock is the strobe for the parallel word.
// - The recovered clock has equal high and low times whatever the duty cycle of the link clock; for an odd period the code holds it high one mclk cycle longer.
// - While the sleep request is held low, every output is driven low.
// - Lanes left floating while the link clock runs read as high, so the word reads all ones.
// - If both lanes and link clock are left floating, the word keeps its last valid value.
// - If the link clock is left floating, the recovered clock is held low.
// - The seven bits of a lane are sampled in order, bit 0 first, at evenly spaced points of the period.
// - The receiver settles within the settle time after the link clock appears; earlier output need not be valid.
// - After the sleep request falls, the sleeping output state is reached within the sleep entry time.
package lvd_pkg;
   localparam int LANES         = 3;
   localparam int LANE_BITS     = 7;
   localparam int WORD_W        = LANES * LANE_BITS;
   localparam int FIFO_DEPTH    = 8;
   localparam longint MCLK_HZ   = 20_000_000;
   localparam int PLL_SETTLE_MS = 10;
   localparam int SETTLE_CYC    = int'((PLL_SETTLE_MS * MCLK_HZ) / 1000);
   localparam int SLEEP_ENTRY_US = 2;
   localparam int SLEEP_CYC     = int'((SLEEP_ENTRY_US * MCLK_HZ) / 1_000_000);
   localparam int LOSS_NS       = 2000;
   localparam int LOSS_CYC      = int'((LOSS_NS * MCLK_HZ) / 1_000_000_000);
   localparam int CNT_W         = 8;
   localparam int PERIOD_MIN    = 7;
   localparam int PERIOD_MAX    = 255;
   localparam int ACC_W         = 12;

   typedef enum logic [1:0] {
      LVD_ST_IDLE   = 2'b00,
      LVD_ST_SETTLE = 2'b01,
      LVD_ST_RUN    = 2'b10,
      LVD_ST_SLEEP  = 2'b11
   } lvd_state_e;
endpackage

// ==== common/lvd_word_if.sv ====
// Valid/ready word carrier between deserializer and its FIFO
`timescale 1ns/1ps
interface lvd_word_if #(parameter int W = 21) ();
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ==== core/lvd_fifo.sv ====
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lvd_fifo #(
   parameter int W     = 21,
   parameter int DEPTH = 8
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic flush,
   lvd_word_if.snk   wr,
   lvd_word_if.src   rd
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_ptr_q;
   logic [AW:0]  rd_ptr_q;
   logic         full;
   logic         empty;
   logic         do_wr;
   logic         do_rd;

   assign empty    = (wr_ptr_q == rd_ptr_q);
   assign full     = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   assign wr.ready = !full && !flush;
   assign rd.valid = !empty;
   assign rd.data  = mem[rd_ptr_q[AW-1:0]];
   assign do_wr    = wr.valid && wr.ready;
   assign do_rd    = rd.ready && !empty;

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_q[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end
endmodule

// ==== core/lvd_deser.sv ====
// Three-lane serial to 21-bit parallel receiver with recovered strobe clock
`timescale 1ns/1ps
module lvd_deser #(
   parameter int SETTLE_CYCLES = lvd_pkg::SETTLE_CYC
) (
   input  wire logic                       mclk,
   input  wire logic                       reset_n,
   input  wire logic                       forwarded_link_clock,
   input  wire logic [lvd_pkg::LANES-1:0]  serial_lane_in,
   input  wire logic                       sleep_request_n,
   output logic      [lvd_pkg::WORD_W-1:0] parallel_word_out,
   output logic                            recovered_strobe_clock,
   output logic                            link_locked
);
   localparam int CW = lvd_pkg::CNT_W;
   localparam int AW = lvd_pkg::ACC_W;
   localparam int SW = $clog2(SETTLE_CYCLES + 1);

   lvd_pkg::lvd_state_e state_q;

   logic [2:0]                  clk_sync_q;
   logic [lvd_pkg::LANES-1:0]   lane_s1_q;
   logic [lvd_pkg::LANES-1:0]   lane_s2_q;
   logic [1:0]                  sleep_sync_q;
   logic                        link_rise;
   logic                        sleep_now;
   logic [CW-1:0]               per_cnt_q;
   logic [CW-1:0]               period_q;
   logic                        clk_lost;
   logic                        period_ok;
   logic [AW-1:0]               acc_q;
   logic [AW-1:0]               target_q;
   logic [2:0]                  bit_idx_q;
   logic                        strobe;
   logic [lvd_pkg::LANE_BITS-1:0] shift_q [lvd_pkg::LANES];
   logic [lvd_pkg::WORD_W-1:0]  word_asm;
   logic                        push_vld_q;
   logic [SW-1:0]               settle_q;
   logic [CW-1:0]               out_cnt_q;
   logic                        out_start;

   lvd_word_if #(.W(lvd_pkg::WORD_W)) push_if ();
   lvd_word_if #(.W(lvd_pkg::WORD_W)) pop_if ();

   // Pins are asynchronous to mclk; the first stage feeds only the second
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         clk_sync_q   <= 3'h0;
         lane_s1_q    <= '0;
         lane_s2_q    <= '0;
         sleep_sync_q <= 2'h0;
      end else begin
         clk_sync_q   <= {clk_sync_q[1:0], forwarded_link_clock};
         lane_s1_q    <= serial_lane_in;
         lane_s2_q    <= lane_s1_q;
         sleep_sync_q <= {sleep_sync_q[0], sleep_request_n};
      end
   end

   assign link_rise = clk_sync_q[1] && !clk_sync_q[2];
   assign sleep_now = !sleep_sync_q[1];

   // Period measured in mclk cycles, saturating so a stopped clock is seen
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         per_cnt_q <= '0;
         period_q  <= '0;
      end else if (link_rise) begin
         per_cnt_q <= '0;
         period_q  <= per_cnt_q + 1'b1;
      end else if (per_cnt_q != CW'(lvd_pkg::PERIOD_MAX)) begin
         per_cnt_q <= per_cnt_q + 1'b1;
      end
   end

   assign clk_lost  = (per_cnt_q >= CW'(lvd_pkg::LOSS_CYC));
   // Band scaled to the sampling clock: fewer than 7 cycles cannot hold 7 strobes
   assign period_ok = !clk_lost && (period_q >= CW'(lvd_pkg::PERIOD_MIN));

   // Half-unit accumulator: sample n is bit k once 14n+7 reaches (2k+1)*P
   // Limitation: only as fine as one mclk cycle, so lane skew must stay small
   assign strobe = (bit_idx_q < 3'(lvd_pkg::LANE_BITS)) && (acc_q >= target_q);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q     <= '0;
         target_q  <= '0;
         bit_idx_q <= 3'h7;
      end else if (link_rise) begin
         acc_q     <= AW'(3 * lvd_pkg::LANE_BITS);
         target_q  <= AW'(period_q);
         bit_idx_q <= 3'h0;
      end else begin
         acc_q <= acc_q + AW'(2 * lvd_pkg::LANE_BITS);
         if (strobe) begin
            target_q  <= target_q + AW'({period_q, 1'b0});
            bit_idx_q <= bit_idx_q + 1'b1;
         end
      end
   end

   // Idle lanes read high through the fail-safe bias, giving an all-ones word
   genvar ln;
   generate
      for (ln = 0; ln < lvd_pkg::LANES; ln++) begin : g_lane
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               shift_q[ln] <= '0;
            end else if (strobe) begin
               shift_q[ln][bit_idx_q] <= lane_s2_q[ln];
            end
         end
         always_comb begin
            word_asm[ln*lvd_pkg::LANE_BITS +: lvd_pkg::LANE_BITS] = shift_q[ln];
         end
      end
   endgenerate

   // Word is pushed one cycle after its last strobe; valid is held until the FIFO takes the word
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         push_vld_q  <= 1'b0;
      end else if (state_q != lvd_pkg::LVD_ST_RUN) begin
         push_vld_q  <= 1'b0;
      end else if (strobe && bit_idx_q == 3'(lvd_pkg::LANE_BITS - 1)) begin
         push_vld_q  <= 1'b1;
      end else if (push_vld_q && push_if.ready) begin
         push_vld_q  <= 1'b0;
      end
   end

   assign push_if.valid = push_vld_q;
   // Shift registers stay whole until the next period's first strobe
   assign push_if.data  = word_asm;

   // Lock and sleep sequencing
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q  <= lvd_pkg::LVD_ST_IDLE;
         settle_q <= '0;
      end else if (sleep_now) begin
         state_q  <= lvd_pkg::LVD_ST_SLEEP;
         settle_q <= '0;
      end else begin
         case (state_q)
            lvd_pkg::LVD_ST_SLEEP: begin
               state_q <= lvd_pkg::LVD_ST_IDLE;
            end
            lvd_pkg::LVD_ST_IDLE: begin
               settle_q <= '0;
               if (period_ok) begin
                  state_q <= lvd_pkg::LVD_ST_SETTLE;
               end
            end
            lvd_pkg::LVD_ST_SETTLE: begin
               if (!period_ok) begin
                  state_q <= lvd_pkg::LVD_ST_IDLE;
               end else if (settle_q == SW'(SETTLE_CYCLES - 1)) begin
                  state_q <= lvd_pkg::LVD_ST_RUN;
               end else begin
                  settle_q <= settle_q + 1'b1;
               end
            end
            default: begin
               if (clk_lost) begin
                  state_q <= lvd_pkg::LVD_ST_IDLE;
               end
            end
         endcase
      end
   end

   lvd_fifo #(
      .W     (lvd_pkg::WORD_W),
      .DEPTH (lvd_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk   (mclk),
      .rst_n (reset_n),
      .flush (state_q != lvd_pkg::LVD_ST_RUN),
      .wr    (push_if),
      .rd    (pop_if)
   );

   // Output period follows the measured link period
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         out_cnt_q <= '0;
      end else if (state_q != lvd_pkg::LVD_ST_RUN || out_cnt_q >= period_q - 1'b1) begin
         out_cnt_q <= '0;
      end else begin
         out_cnt_q <= out_cnt_q + 1'b1;
      end
   end

   assign out_start    = (state_q == lvd_pkg::LVD_ST_RUN) && (out_cnt_q == '0);
   assign pop_if.ready = out_start;

   // Data moves at the falling edge, half a period before the strobing rise
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         parallel_word_out <= '0;
      end else if (state_q == lvd_pkg::LVD_ST_SLEEP) begin
         parallel_word_out <= '0;
      end else if (out_start && pop_if.valid) begin
         parallel_word_out <= pop_if.data;
      end
   end // IDLE or SETTLE: last word kept; SLEEP clears it

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         recovered_strobe_clock <= 1'b0;
      end else if (state_q != lvd_pkg::LVD_ST_RUN) begin
         recovered_strobe_clock <= 1'b0;
      end else if (out_start) begin
         recovered_strobe_clock <= 1'b0;
      end else if (out_cnt_q == (period_q >> 1)) begin
         recovered_strobe_clock <= 1'b1;
      end
   end // Rise is the strobe

   assign link_locked = (state_q == lvd_pkg::LVD_ST_RUN);
endmodule

// ==== verif/lvd_deser_checker.sv ====
// Port checks for the deserializer
`timescale 1ns/1ps
module lvd_deser_checker #(parameter int SETTLE_CYCLES = 20) (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        forwarded_link_clock,
   input wire logic        sleep_request_n,
   input wire logic [20:0] parallel_word_out,
   input wire logic        recovered_strobe_clock,
   input wire logic        link_locked
);
   logic       prev_q, hv_q, lk_q;
   logic [7:0] len_q, hi_q, idle_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Phase lengths; link clock sampled raw, so loss limits keep a margin
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {prev_q, hv_q, lk_q, len_q, hi_q, idle_q} <= 27'h0;
      end else begin
         prev_q <= recovered_strobe_clock;
         lk_q   <= forwarded_link_clock;
         len_q  <= (recovered_strobe_clock != prev_q) ? 8'h1 : len_q + 8'h1;
         hv_q   <= link_locked && (hv_q || (prev_q && !recovered_strobe_clock));
         idle_q <= (forwarded_link_clock && !lk_q) ? 8'h0 : idle_q + {7'h0, idle_q != 8'hff};
         if (prev_q && !recovered_strobe_clock) hi_q <= len_q;
      end
   end
   sequence s_asleep;
      !sleep_request_n [*8];
   endsequence
   sequence s_low3;
      !recovered_strobe_clock [*3];
   endsequence
   AST_SLEEP_ENTRY: assert property ($fell(sleep_request_n) |-> ##[1:40] parallel_word_out == 21'h0)
      else $error("slow sleep entry");
   AST_SLEEP_QUIET: assert property (s_asleep |-> {parallel_word_out, recovered_strobe_clock} == 22'h0)
      else $error("active in sleep");
   AST_CLK_LOST: assert property (idle_q >= 8'h32 |-> !recovered_strobe_clock && !link_locked)
      else $error("clock out after loss");
   AST_WORD_HELD: assert property (idle_q >= 8'h32 && sleep_request_n |-> $stable(parallel_word_out))
      else $error("word moved without clock");
   AST_CHANGE_LOW: assert property ($changed(parallel_word_out) && link_locked |-> s_low3)
      else $error("word moved near strobe");
   AST_DUTY: assert property (recovered_strobe_clock && !prev_q && hv_q |-> len_q == hi_q || len_q + 8'h1 == hi_q)
      else $error("uneven duty");
   AST_IDLE_LOW: assert property (!link_locked [*2] |-> !recovered_strobe_clock)
      else $error("clock out while unlocked");
   AST_LOCK_LIVE: assert property ($rose(link_locked) |-> idle_q < 8'h10)
      else $error("lock without link clock");
endmodule
bind lvd_deser lvd_deser_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_lvd_deser_checker (
   .mclk(mclk), .reset_n(reset_n), .forwarded_link_clock(forwarded_link_clock), .sleep_request_n(sleep_request_n),
   .parallel_word_out(parallel_word_out), .recovered_strobe_clock(recovered_strobe_clock), .link_locked(link_locked));

// ==== verif/lvd_ser_model.sv ====
// Serializer model: forwarded clock plus three lanes
`timescale 1ns/1ps
module lvd_ser_model (
   input  wire logic [20:0] word,
   input  wire logic        run,
   input  wire logic        float_lanes,
   output logic             link_clk,
   output logic [2:0]       lanes
);
   logic [20:0] w;
   initial begin
      link_clk = 1'b0;
      lanes = 3'h7;
      #22; // Link rise just ahead of an mclk edge keeps samples inside bit cells
      forever begin
         w = run ? word : 21'h1fffff; // Released lanes bias high
         for (int h = 0; h < 14; h++) begin
            link_clk = run && h < 7; // Idles low when stopped
            for (int l = 0; l < 3; l++) lanes[l] = float_lanes | w[l * 7 + h / 2];
            #(400.0 / 14.0);
         end
      end
   end
endmodule

// ==== verif/lvd_deser_tb.sv ====
// Self-checking bench: serializer model into the deserializer
`timescale 1ns/1ps
module lvd_deser_tb;
   localparam logic [20:0] PRE = 21'h155555;
   logic        mclk, reset_n, sleep_request_n, run, float_lanes, link_clk, rsc, locked, cmp_en, armed;
   logic [2:0]  lanes;
   logic [20:0] word, pword, nw;
   logic [20:0] exp_q[$];
   int          err_total, checked, n;
   lvd_ser_model i_lvd_ser_model (.word(word), .run(run), .float_lanes(float_lanes), .link_clk(link_clk), .lanes(lanes));
   lvd_deser #(.SETTLE_CYCLES(20)) i_lvd_deser (.mclk(mclk), .reset_n(reset_n), .forwarded_link_clock(link_clk),
      .serial_lane_in(lanes), .sleep_request_n(sleep_request_n), .parallel_word_out(pword),
      .recovered_strobe_clock(rsc), .link_locked(locked));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic check(input logic [20:0] got, input logic [20:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   function automatic logic cond(input int sel);
      case (sel)
         0: return locked === 1'b1;
         1: return pword === 21'h1fffff;
         2: return {pword, rsc, locked} === 23'h0;
         3: return exp_q.size() == 0;
         default: return {rsc, locked} === 2'h0;
      endcase
   endfunction
   task automatic wait_for(input int sel, input int bound);
      checked++;
      for (n = 0; !cond(sel) && n < bound; n++) @(posedge mclk);
      if (n >= bound) begin
         err_total++;
         $display("[FAIL] %0t wait %0d timed out", $time, sel);
         stop_test();
      end
   endtask
   // Captured on the rising strobe as downstream logic would; preamble skipped
   always @(posedge rsc) begin
      if (cmp_en && pword !== PRE) armed = 1'b1;
      if (armed && exp_q.size() > 0) check(pword, exp_q.pop_front());
   end
   initial begin
      {reset_n, run, float_lanes, cmp_en, armed} = 5'h0;
      sleep_request_n = 1'b1;
      word = PRE;
      {err_total, checked} = 64'h0;
      void'($urandom(32'h3ec3));
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      run <= 1'b1;
      wait_for(0, 400);
      repeat (40) @(posedge mclk);
      cmp_en = 1'b1;
      // One new word per 400 ns link period
      for (int i = 0; i < 24; i++) begin
         repeat (8) @(posedge mclk);
         nw = 21'($urandom());
         if (nw === PRE) nw = ~nw;
         word <= nw;
         exp_q.push_back(nw);
      end
      wait_for(3, 200);
      run <= 1'b0;
      wait_for(4, 100);
      repeat (20) @(posedge mclk);
      check(pword, nw);
      float_lanes <= 1'b1;
      run <= 1'b1;
      wait_for(0, 400);
      wait_for(1, 200);
      sleep_request_n <= 1'b0;
      wait_for(2, 40);
      repeat (30) @(posedge mclk);
      check(pword | {20'h0, rsc | locked}, 21'h0);
      sleep_request_n <= 1'b1;
      float_lanes <= 1'b0;
      wait_for(0, 400);
      stop_test();
   end
endmodule
